/* verilog/pwc_wave_counter.sv */
// What this block does
// - One shared 15-bit counter feeds four compare channels.
// - Mode bit picks up-only or up-then-down counting.
// - Period top value register sets the top; prescaler sets the tick.
// - Top below compare: no edges, falling-first output stays high.
// - Compare registers are internal, loaded only from the word stream.
// - Top register writes are safe at any time.
// - Wave layout takes the top from the stream, not the register.
// - Other layouts sample the top register at start and each load.
// - Up mode wraps to zero at top and outputs invert there.
// - Falling-first: compare 0 holds low, compare at top holds high in up mode only.
// - Up mode pulses are edge aligned at the wrap.
// - Up mode period is top ticks, step is one tick.
// - Up-down mode turns down at top; output inverts on second match.
// - Up-down mode pulses are centred on the turning point.
// - Up-down period is twice top ticks, step two ticks.
// - New duty values arrive from memory without glitches.
// - Word bit 15 is polarity, bits 14 to 0 the compare value.
// - Wave layout takes four words: three compares, then the top.
// - Begin from idle fetches the first set before counting.
// - Stop while running ends at period end, in fetch at once; signals stopped, pins go idle.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module pwc_wave_counter (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  input  wire logic        loadValid,
  input  wire logic [15:0] loadData,
  output logic             loadReady,
  output logic      [3:0]  pwmOut,
  output logic             stoppedEvent
);
  pwc_pkg::pwc_state_type state_q;

  logic        upDown_q;
  logic [1:0]  layout_q;
  logic [2:0]  presc_q;
  logic [14:0] periodTop_q;
  logic [3:0]  idleLvl_q;
  logic        stopPend_q;
  logic        stopped_q;
  logic [6:0]  prescCnt_q;
  logic [14:0] count_q;
  logic        countDown_q;
  logic [14:0] shCmp_q [4];
  logic [3:0]  shPol_q;
  logic [14:0] shTop_q;
  logic [1:0]  wordIdx_q;
  logic        pending_q;
  logic [14:0] actCmp_q [4];
  logic [3:0]  actPol_q;
  logic [14:0] actTop_q;
  logic        actUpDown_q;
  logic        actWave_q;

  logic        running;
  logic        tick;
  logic [6:0]  prescLimit;
  logic [15:0] countInc;
  logic        upReach;
  logic        periodEnd;
  logic        taskBegin;
  logic        taskStop;
  logic        clearStop;
  logic        acceptWord;
  logic        setDone;
  logic        applyNow;
  logic        goIdle;
  logic [14:0] dataCmp;
  logic        dataPol;

  pwc_cnt_if cntBus ();

  // Register strobes and task pulses decoded from the write port.
  assign taskBegin = regWrite && regAddr == pwc_pkg::AddrTasks
                     && regWrData[pwc_pkg::TaskBeginBit];
  assign taskStop  = regWrite && regAddr == pwc_pkg::AddrTasks
                     && regWrData[pwc_pkg::TaskStopBit];
  assign clearStop = regWrite && regAddr == pwc_pkg::AddrStatus
                     && regWrData[pwc_pkg::StatStopBit];

  // Base clock divider: one tick every two to the power prescale cycles.
  assign running    = state_q == pwc_pkg::StRun;
  assign prescLimit = 7'((8'h01 << presc_q) - 8'h01);
  assign tick       = running && (prescCnt_q >= prescLimit);

  // Wrap and turn detection of the shared counter.
  assign countInc  = {1'b0, count_q} + 16'h0001;
  assign upReach   = countInc >= {1'b0, actTop_q};
  assign periodEnd = tick && (actUpDown_q
                     ? (countDown_q && count_q <= 15'h0001)
                     : upReach);

  // Stream word decode: top bit polarity, low bits compare value.
  assign dataCmp    = loadData[14:0];
  assign dataPol    = loadData[pwc_pkg::WordPolBit];
  assign acceptWord = loadValid && loadReady;
  assign setDone    = acceptWord && (wordIdx_q ==
                      ((layout_q == pwc_pkg::LayoutCommon)
                       ? 2'h0 : pwc_pkg::LastWordIdx));
  assign applyNow   = pending_q
                      && (state_q == pwc_pkg::StFetch || periodEnd);

  // Stop in fetch is immediate; while running it waits for period end.
  assign goIdle = (state_q == pwc_pkg::StFetch && taskStop)
                  || (running && periodEnd
                      && (stopPend_q || taskStop));

  assign cntBus.count   = count_q;
  assign cntBus.running = running;

  // Software control registers; the top register may change any time.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      upDown_q    <= 1'b0;
      layout_q    <= pwc_pkg::LayoutCommon;
      presc_q     <= 3'h0;
      periodTop_q <= pwc_pkg::TopReset;
      idleLvl_q   <= pwc_pkg::IdleReset;
    end else if (regWrite) begin
      if (regAddr == pwc_pkg::AddrCtrl) begin
        upDown_q <= regWrData[pwc_pkg::CtrlUpDownBit];
        layout_q <= regWrData[pwc_pkg::CtrlLayoutLsb +: 2];
        presc_q  <= regWrData[pwc_pkg::CtrlPrescLsb +: 3];
      end
      if (regAddr == pwc_pkg::AddrTop) begin
        periodTop_q <= regWrData[14:0];
      end
      if (regAddr == pwc_pkg::AddrIdle) begin
        idleLvl_q <= regWrData[3:0];
      end
    end
  end

  // Sequence state: idle, fetching the first set, running.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= pwc_pkg::StIdle;
    end else begin
      case (state_q)
        pwc_pkg::StIdle: begin
          if (taskBegin) begin
            state_q <= pwc_pkg::StFetch;
          end
        end
        pwc_pkg::StFetch: begin
          if (goIdle) begin
            state_q <= pwc_pkg::StIdle;
          end else if (applyNow) begin
            state_q <= pwc_pkg::StRun;
          end
        end
        pwc_pkg::StRun: begin
          if (goIdle) begin
            state_q <= pwc_pkg::StIdle;
          end
        end
        default: begin
          state_q <= pwc_pkg::StIdle;
        end
      endcase
    end
  end

  // Pending stop request and sticky stopped flag; set wins over clear.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stopPend_q   <= 1'b0;
      stopped_q    <= 1'b0;
      stoppedEvent <= 1'b0;
    end else begin
      stoppedEvent <= goIdle;
      if (goIdle || state_q == pwc_pkg::StIdle) begin
        stopPend_q <= 1'b0;
      end else if (taskStop) begin
        stopPend_q <= 1'b1;
      end
      if (goIdle) begin
        stopped_q <= 1'b1;
      end else if (clearStop) begin
        stopped_q <= 1'b0;
      end
    end
  end

  // Prescaler counting base clock ticks while generation runs.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prescCnt_q <= 7'h00;
    end else if (!running || tick) begin
      prescCnt_q <= 7'h00;
    end else begin
      prescCnt_q <= prescCnt_q + 7'h01;
    end
  end

  // Shared counter: up mode wraps at top, up-down mode turns at top.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q     <= 15'h0000;
      countDown_q <= 1'b0;
    end else if (!running) begin
      count_q     <= 15'h0000;
      countDown_q <= 1'b0;
    end else if (tick) begin
      if (!actUpDown_q) begin
        count_q <= upReach ? 15'h0000 : countInc[14:0];
      end else if (countDown_q) begin
        if (count_q <= 15'h0001) begin
          count_q     <= 15'h0000;
          countDown_q <= 1'b0;
        end else begin
          count_q <= count_q - 15'h0001;
        end
      end else if (upReach) begin
        count_q     <= actTop_q;
        countDown_q <= 1'b1;
      end else begin
        count_q <= countInc[14:0];
      end
    end
  end

  // Word index and ready toward the stream; ready drops once a set is
  // held until the running period ends and takes it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loadReady <= 1'b0;
      wordIdx_q <= 2'h0;
      pending_q <= 1'b0;
    end else if (goIdle || state_q == pwc_pkg::StIdle) begin
      loadReady <= taskBegin && state_q == pwc_pkg::StIdle;
      wordIdx_q <= 2'h0;
      pending_q <= 1'b0;
    end else begin
      if (acceptWord) begin
        wordIdx_q <= setDone ? 2'h0 : wordIdx_q + 2'h1;
      end
      if (setDone) begin
        loadReady <= 1'b0;
        pending_q <= 1'b1;
      end else if (applyNow) begin
        loadReady <= 1'b1;
        pending_q <= 1'b0;
      end
    end
  end

  // Shadow set filled from the stream, never from the register port.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shCmp_q <= '{4{15'h0000}};
      shPol_q <= 4'h0;
      shTop_q <= pwc_pkg::TopReset;
    end else if (acceptWord) begin
      if (layout_q == pwc_pkg::LayoutCommon) begin
        shCmp_q <= '{4{dataCmp}};
        shPol_q <= {4{dataPol}};
      end else if (layout_q == pwc_pkg::LayoutWave
                   && wordIdx_q == pwc_pkg::LastWordIdx) begin
        shTop_q <= dataCmp;
      end else begin
        shCmp_q[wordIdx_q] <= dataCmp;
        shPol_q[wordIdx_q] <= dataPol;
      end
    end
  end

  // Active set taken only at a boundary, with mode and top sampled there.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      actCmp_q    <= '{4{15'h0000}};
      actPol_q    <= 4'h0;
      actTop_q    <= pwc_pkg::TopReset;
      actUpDown_q <= 1'b0;
      actWave_q   <= 1'b0;
    end else if (applyNow) begin
      actCmp_q    <= shCmp_q;
      actPol_q    <= shPol_q;
      actUpDown_q <= upDown_q;
      actWave_q   <= layout_q == pwc_pkg::LayoutWave;
      if (layout_q == pwc_pkg::LayoutWave) begin
        actTop_q <= shTop_q;
      end else begin
        actTop_q <= periodTop_q;
      end
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData <= 32'h0000_0000;
    end else if (!regRead) begin
      regRdData <= 32'h0000_0000;
    end else begin
      case (regAddr)
        pwc_pkg::AddrCtrl:   regRdData <= 32'({presc_q, 1'b0, layout_q,
                                               upDown_q});
        pwc_pkg::AddrTop:    regRdData <= 32'(periodTop_q);
        pwc_pkg::AddrIdle:   regRdData <= 32'(idleLvl_q);
        pwc_pkg::AddrStatus: regRdData <= 32'({state_q == pwc_pkg::StFetch,
                                               stopped_q, running});
        pwc_pkg::AddrCount:  regRdData <= 32'(count_q);
        default:             regRdData <= 32'h0000_0000;
      endcase
    end
  end

  // Four compare channels share the counter; the wave layout parks the
  // last channel at its idle level.
  for (genvar i = 0; i < pwc_pkg::Channels; i++) begin : g_chan
    pwc_channel u_chan (
      .clk       (clk),
      .reset     (reset),
      .bus       (cntBus.chan),
      .cmpValue  (actCmp_q[i]),
      .fallFirst (actPol_q[i]),
      .enable    (!(actWave_q && i == pwc_pkg::WaveTopSlot)),
      .idleLevel (idleLvl_q[i]),
      .pinOut    (pwmOut[i])
    );
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_top_only_at_apply;
    !applyNow |=> $stable(actTop_q);
  endproperty
  a_top_only_at_apply: assert property (p_top_only_at_apply)
    else $error("Active top changed outside a boundary.");

  property p_up_wrap;
    tick && !actUpDown_q && upReach && !goIdle |=> count_q == 15'h0000;
  endproperty
  a_up_wrap: assert property (p_up_wrap)
    else $error("Up counter did not wrap to zero at top.");

  property p_down_turn;
    tick && actUpDown_q && !countDown_q && upReach && !goIdle
      |=> countDown_q && count_q == $past(actTop_q);
  endproperty
  a_down_turn: assert property (p_down_turn)
    else $error("Up-down counter did not turn at top.");

  property p_wave_top;
    applyNow && layout_q == pwc_pkg::LayoutWave
      |=> actTop_q == $past(shTop_q);
  endproperty
  a_wave_top: assert property (p_wave_top)
    else $error("Wave layout top not taken from the stream.");

  property p_reg_top;
    applyNow && layout_q != pwc_pkg::LayoutWave
      |=> actTop_q == $past(periodTop_q);
  endproperty
  a_reg_top: assert property (p_reg_top)
    else $error("Top register not sampled at load.");

  property p_stop_idle;
    goIdle |=> state_q == pwc_pkg::StIdle && stoppedEvent && !loadReady
      ##1 pwmOut == idleLvl_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("Stop did not return pins to idle.");

  property p_begin_fetch;
    state_q == pwc_pkg::StIdle && taskBegin
      |=> state_q == pwc_pkg::StFetch && loadReady && !running;
  endproperty
  a_begin_fetch: assert property (p_begin_fetch)
    else $error("Begin did not fetch before counting.");

  property p_decode_word;
    acceptWord && layout_q == pwc_pkg::LayoutSingle && wordIdx_q == 2'h0
      |=> shCmp_q[0] == $past(dataCmp) && shPol_q[0] == $past(dataPol);
  endproperty
  a_decode_word: assert property (p_decode_word)
    else $error("Stream word decoded wrongly.");

  property p_apply_boundary;
    applyNow && running |-> periodEnd;
  endproperty
  a_apply_boundary: assert property (p_apply_boundary)
    else $error("New set applied inside a period.");

  c_stop: cover property (goIdle && running);
  c_wave: cover property (applyNow && layout_q == pwc_pkg::LayoutWave);
  c_turn: cover property (tick && actUpDown_q && !countDown_q && upReach);
  c_reload: cover property (applyNow && running ##1 acceptWord);
endmodule // pwc_wave_counter

/* verilog/pwc_pkg.sv */
package pwc_pkg;
  // Data path widths.
  localparam int CntWidth   = 15;
  localparam int Channels   = 4;
  localparam int AddrWidth  = 8;
  localparam int DataWidth  = 32;
  localparam int WordWidth  = 16;
  localparam int PrescWidth = 3;
  localparam int PrescCntW  = 7;

  // Register byte addresses.
  localparam logic [7:0] AddrCtrl   = 8'h00;
  localparam logic [7:0] AddrTop    = 8'h04;
  localparam logic [7:0] AddrIdle   = 8'h08;
  localparam logic [7:0] AddrTasks  = 8'h0c;
  localparam logic [7:0] AddrStatus = 8'h10;
  localparam logic [7:0] AddrCount  = 8'h14;

  // Field positions.
  localparam int CtrlUpDownBit = 0;
  localparam int CtrlLayoutLsb = 1;
  localparam int CtrlPrescLsb  = 4;
  localparam int TaskBeginBit  = 0;
  localparam int TaskStopBit   = 1;
  localparam int StatRunBit    = 0;
  localparam int StatStopBit   = 1;
  localparam int StatFetchBit  = 2;
  localparam int WordPolBit    = 15;

  // Load layouts held in the control register.
  localparam logic [1:0] LayoutCommon = 2'h0;
  localparam logic [1:0] LayoutSingle = 2'h1;
  localparam logic [1:0] LayoutWave   = 2'h2;
  localparam logic [1:0] LastWordIdx  = 2'h3;
  localparam int WaveTopSlot = 3;

  // Reset values.
  localparam logic [14:0] TopReset  = 15'h03e8;
  localparam logic [3:0]  IdleReset = 4'h0;

  typedef enum logic [1:0] {StIdle, StFetch, StRun} pwc_state_type;
endpackage

/* verilog/pwc_cnt_if.sv */
`timescale 1ns/1ps
// Shared counter value and run state fanned out to the channels.
interface pwc_cnt_if;
  logic [14:0] count;
  logic        running;
  modport counter (output count, output running);
  modport chan (input count, input running);
endinterface

/* verilog/pwc_channel.sv */
`timescale 1ns/1ps
module pwc_channel (
  input  wire logic  clk,
  input  wire logic  reset,
  pwc_cnt_if.chan    bus,
  input  wire logic [14:0] cmpValue,
  input  wire logic  fallFirst,
  input  wire logic  enable,
  input  wire logic  idleLevel,
  output logic       pinOut
);
  logic below;

  // Counter below compare decides the level; a top below compare never
  // lets the counter reach it, so the level simply holds.
  assign below = bus.count < cmpValue;

  // Output flop: idle level when stopped or disabled, else compare level.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pinOut <= 1'b0;
    end else if (!bus.running || !enable) begin
      pinOut <= idleLevel;
    end else begin
      pinOut <= fallFirst ? below : !below;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_zero_low;
    bus.running && enable && fallFirst && cmpValue == 15'h0000
      |=> !pinOut;
  endproperty
  a_zero_low: assert property (p_zero_low)
    else $error("Zero compare did not hold output low.");

  property p_above_top_high;
    bus.running && enable && fallFirst && (bus.count < cmpValue)
      |=> pinOut;
  endproperty
  a_above_top_high: assert property (p_above_top_high)
    else $error("Output not high while counter below compare.");
endmodule // pwc_channel

/* verification/pwc_pin_load.sv */
`timescale 1ns/1ps
// Load on the four channel pins; times each pulse and each period.
module pwc_pin_load (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [3:0]       pins,
  output logic      [3:0][15:0] highLen,
  output logic      [3:0][15:0] perLen
);
  logic [3:0]       prevQ;
  logic [3:0][15:0] sinceQ;
  logic [3:0][15:0] runQ;

  // A period runs from one rising edge to the next; the pulse ends falling.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prevQ   <= '0;
      sinceQ  <= '0;
      runQ    <= '0;
      highLen <= '0;
      perLen  <= '0;
    end else begin
      prevQ <= pins;
      for (int i = 0; i < 4; i++) begin
        if (pins[i] && !prevQ[i]) begin
          perLen[i] <= sinceQ[i];
          sinceQ[i] <= 16'h1;
          runQ[i]   <= 16'h1;
        end else begin
          sinceQ[i] <= sinceQ[i] + 16'h1;
          if (pins[i]) runQ[i] <= runQ[i] + 16'h1;
          if (!pins[i] && prevQ[i]) highLen[i] <= runQ[i];
        end
      end
    end
  end
endmodule // pwc_pin_load

/* verification/pwc_wave_counter_tb_top.sv */
`timescale 1ns/1ps
module pwc_wave_counter_tb_top;
  logic             clk;
  logic             reset;
  logic [7:0]       regAddr;
  logic [31:0]      regWrData;
  logic             regWrite;
  logic             regRead;
  logic [31:0]      regRdData;
  logic             loadValid;
  logic [15:0]      loadData;
  logic             loadReady;
  logic [3:0]       pwmOut;
  logic             stoppedEvent;
  logic [3:0][15:0] highLen;
  logic [3:0][15:0] perLen;
  int               num_errors;
  int               samples_checked;
  int               cycles;
  logic [31:0]      seed;

  pwc_wave_counter dut_u (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .loadValid(loadValid), .loadData(loadData),
    .loadReady(loadReady), .pwmOut(pwmOut), .stoppedEvent(stoppedEvent));

  pwc_pin_load load_u (.clk(clk), .reset(reset), .pins(pwmOut),
    .highLen(highLen), .perLen(perLen));

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  // Offers one stream word and holds it until the block takes it.
  task automatic feed(input logic [15:0] w);
    int n = 0;
    @(posedge clk);
    loadData  <= w;
    loadValid <= 1'b1;
    @(posedge clk);
    while (loadReady !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("word taken", 32'h1, 32'(n < 2000));
    loadValid <= 1'b0;
    loadData  <= ~w;
  endtask

  // Programs mode and top, begins a sequence and hands over the words.
  task automatic start(input logic [31:0] ctrl, input logic [14:0] top,
                       input logic [15:0] w[$]);
    logic [31:0] d;
    wr(pwc_pkg::AddrCtrl, ctrl);
    wr(pwc_pkg::AddrTop, 32'(top));
    wr(pwc_pkg::AddrTasks, 32'h1);
    rd(pwc_pkg::AddrStatus, d);
    chk("fetching first", 32'h4, d);
    foreach (w[i]) feed(w[i]);
    rd(pwc_pkg::AddrStatus, d);
    chk("running", 32'h1, 32'(d[0]));
  endtask

  // Stops generation and checks the event, idle pins and sticky flag.
  task automatic stop(input logic [3:0] idle);
    logic [31:0] d;
    int          n = 0;
    wr(pwc_pkg::AddrTasks, 32'h2);
    while (stoppedEvent !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("stopped event", 32'h1, 32'(n < 400));
    repeat (2) @(posedge clk);
    #1 chk("idle pins", 32'(idle), 32'(pwmOut));
    rd(pwc_pkg::AddrStatus, d);
    chk("stopped flag", 32'h2, d);
    wr(pwc_pkg::AddrStatus, 32'h2);
    rd(pwc_pkg::AddrStatus, d);
    chk("flag cleared", 32'h0, d);
  endtask

  // Watches one pin for n cycles and expects it never to move.
  task automatic hold(input int ch, input logic lvl, input int n);
    logic bad = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (pwmOut[ch] !== lvl) bad = 1'b1;
    end
    chk($sformatf("held pin %0d", ch), 32'(lvl), 32'(lvl ^ bad));
  endtask

  function automatic logic [31:0] ctrlOf(input logic ud,
                                         input logic [1:0] lay);
    ctrlOf = 32'(ud) | (32'(lay) << pwc_pkg::CtrlLayoutLsb);
  endfunction

  // Random compare value strictly between 0 and hi.
  function automatic logic [14:0] rnd(input int hi);
    rnd = 15'(1 + ({$random(seed)} % (hi - 1)));
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0]  q;
    logic [3:0]  p;
    logic [14:0] t;
    logic [14:0] c0;
    logic [14:0] c1;
    clk = 1'b0;
    reset = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    loadValid = 1'b0;
    loadData = 16'h0;
    seed = 32'h8c9e62e9;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Register reset values and the unmapped place.
    rd(pwc_pkg::AddrTop, d);
    chk("top reset", 32'(pwc_pkg::TopReset), d);
    rd(pwc_pkg::AddrIdle, d);
    chk("idle reset", 32'h0, d);
    rd(pwc_pkg::AddrTasks, d);
    chk("tasks read", 32'h0, d);
    wr(8'hfc, 32'hffffffff);
    rd(8'hfc, d);
    chk("unmapped", 32'h0, d);
    $display("test registers done");
    // Up mode, one word per channel, random tops and compares.
    for (int k = 0; k < 3; k++) begin
      t = 15'(16 + ({$random(seed)} % 48));
      c0 = rnd(t);
      c1 = rnd(t);
      wr(pwc_pkg::AddrIdle, 32'h5);
      start(ctrlOf(1'b0, pwc_pkg::LayoutSingle), t,
            '{{1'b1, c0}, {1'b0, c1}, 16'h8000, {1'b1, t}});
      repeat (3 * t + 10) @(posedge clk);
      chk("ch0 width", 32'(c0), 32'(highLen[0]));
      chk("ch0 period", 32'(t), 32'(perLen[0]));
      chk("ch1 width", 32'(t - c1), 32'(highLen[1]));
      chk("ch1 period", 32'(t), 32'(perLen[1]));
      hold(2, 1'b0, 2 * t);
      hold(3, 1'b1, 2 * t);
      q = 2'b00;
      p = pwmOut;
      repeat (t + 2) begin
        @(posedge clk);
        #1 if (pwmOut[0] && !p[0]) q = {p[1], pwmOut[1]};
        p = pwmOut;
      end
      chk("edges at wrap", 32'h2, 32'(q));
      stop(4'h5);
    end
    $display("test up mode done");
    // Up-and-down mode: doubled period, two ticks per compare step.
    t = 30;
    c0 = rnd(t - 1);
    wr(pwc_pkg::AddrIdle, 32'h0);
    start(ctrlOf(1'b1, pwc_pkg::LayoutSingle), t,
          '{{1'b1, c0}, {1'b1, c0 + 15'h1}, 16'h8000, 16'h8000});
    repeat (6 * t) @(posedge clk);
    chk("updown period", 32'(2 * t), 32'(perLen[0]));
    chk("updown step", 32'h2, 32'(highLen[1] - highLen[0]));
    // Both edges of the narrower pulse must fall inside the wider one.
    q = 2'b00;
    p = pwmOut;
    repeat (2 * t) begin
      @(posedge clk);
      #1 if (pwmOut[0] != p[0] && p[1] && pwmOut[1]) q = q + 2'b01;
      p = pwmOut;
    end
    chk("centred pulses", 32'h2, 32'(q));
    hold(2, 1'b0, 2 * t);
    stop(4'h0);
    $display("test up-down done");
    // Wave layout: top comes from the fourth word, the register is ignored.
    c0 = rnd(24);
    c1 = rnd(24);
    wr(pwc_pkg::AddrIdle, 32'h8);
    // Prescale of one here, so every counter step lasts two clocks.
    start(ctrlOf(1'b0, pwc_pkg::LayoutWave)
          | (32'h1 << pwc_pkg::CtrlPrescLsb), 15'd50,
          '{{1'b1, c0}, {1'b0, c1}, {1'b1, 15'd60}, 16'd24});
    rd(pwc_pkg::AddrCtrl, d);
    chk("ctrl readback", ctrlOf(1'b0, pwc_pkg::LayoutWave)
        | (32'h1 << pwc_pkg::CtrlPrescLsb), d);
    repeat (150) @(posedge clk);
    rd(pwc_pkg::AddrCount, d);
    chk("count below top", 32'h1, 32'(d < 32'd24));
    chk("wave period", 32'd48, 32'(perLen[0]));
    chk("wave width", 32'(2 * c0), 32'(highLen[0]));
    chk("wave ch1", 32'(2 * (24 - c1)), 32'(highLen[1]));
    hold(2, 1'b1, 60);
    hold(3, 1'b1, 60);
    stop(4'h8);
    $display("test wave layout done");
    // Top rewritten while words keep arriving; only whole periods result.
    wr(pwc_pkg::AddrIdle, 32'h0);
    start(ctrlOf(1'b0, pwc_pkg::LayoutCommon), 15'd40, '{16'h8005});
    for (int i = 0; i < 12; i++) begin
      if (i == 4) wr(pwc_pkg::AddrTop, 32'd24);
      feed(16'h8005);
      if (i > 1) chk("whole period", 32'h1,
                     32'(perLen[0] == 40 || perLen[0] == 24));
    end
    // A software write to the count place must not reach the compares.
    wr(pwc_pkg::AddrCount, $random(seed));
    repeat (60) @(posedge clk);
    chk("new top", 32'd24, 32'(perLen[0]));
    chk("shared period", 32'd24, 32'(perLen[3]));
    chk("common width", 32'd5, 32'(highLen[2]));
    stop(4'h0);
    $display("test top rewrite done");
    end_of_test();
  end
endmodule // pwc_wave_counter_tb_top
